// ===== shared/cia_pkg.sv
`default_nettype none
package cia_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int CH       = 16;
    localparam int CHW      = 4;
    localparam int NSEL     = 16;
    localparam int SELW     = 4;
    localparam int NALM     = 6;

    // ------------------------------------------------------------
    // configuration word selectors
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_CTL    = 4'h0;
    localparam logic [3:0] SEL_MASK   = 4'h1;
    localparam logic [3:0] SEL_ITIME  = 4'h2;
    localparam logic [3:0] SEL_OFFSET = 4'h3;
    localparam logic [3:0] SEL_LOLO   = 4'h4;
    localparam logic [3:0] SEL_LO     = 4'h5;
    localparam logic [3:0] SEL_HI     = 4'h6;
    localparam logic [3:0] SEL_HIHI   = 4'h7;
    localparam logic [3:0] SEL_DB_LL  = 4'h8;
    localparam logic [3:0] SEL_DB_L   = 4'h9;
    localparam logic [3:0] SEL_DB_H   = 4'hA;
    localparam logic [3:0] SEL_DB_HH  = 4'hB;
    localparam logic [3:0] SEL_PRATE  = 4'hC;
    localparam logic [3:0] SEL_NRATE  = 4'hD;
    localparam logic [3:0] SEL_RINTV  = 4'hE;

    // ------------------------------------------------------------
    // control and mask word fields
    // ------------------------------------------------------------
    localparam int CTL_RNG_LSB = 0;
    localparam int CTL_FMT     = 2;
    localparam int CTL_FILT    = 3;
    localparam int CTL_DIAG    = 4;
    localparam int CTL_FAULT   = 5;
    localparam int MASK_DIAG   = 0;
    localparam int MASK_FAULT  = 8;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    typedef enum logic [1:0] {
        RNG_420 = 2'b00,
        RNG_020 = 2'b01,
        RNG_ENH = 2'b11
    } cia_range_t;

    // ------------------------------------------------------------
    // alarm bit positions
    // ------------------------------------------------------------
    localparam int ALM_LOLO = 0;
    localparam int ALM_LO   = 1;
    localparam int ALM_HI   = 2;
    localparam int ALM_HIHI = 3;
    localparam int ALM_NEG  = 4;
    localparam int ALM_POS  = 5;

    // ------------------------------------------------------------
    // scaling: raw input in 1/8 uA steps
    // ------------------------------------------------------------
    localparam logic signed [19:0] RAW_4MA   = 20'sh07D00;
    localparam int                 SHIFT_05  = 2;
    localparam logic        [19:0] DIV_0625  = 20'h00005;
    localparam logic signed [19:0] CNT_MAX   = 20'sh07FFF;
    localparam logic signed [19:0] CNT_MIN   = -20'sh08000;
    localparam logic [15:0] SIGN_NEG = 16'hFFFF;
    localparam logic [15:0] SIGN_POS = 16'h0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] RATE_MIN_MS = 16'h003C;
    localparam logic [15:0] BLANK_MS    = 16'h0064;
    localparam logic [9:0]  MS_PER_S    = 10'h3E8;
endpackage
`default_nettype wire

// ===== core/cia_level_alarm.sv
`timescale 1ns/10ps
`default_nettype none
module cia_level_alarm
(
    input  wire logic signed [15:0] val_i,
    input  wire logic signed [15:0] lolo_i,
    input  wire logic signed [15:0] lo_i,
    input  wire logic signed [15:0] hi_i,
    input  wire logic signed [15:0] hihi_i,
    input  wire logic        [15:0] db_lolo_i,
    input  wire logic        [15:0] db_lo_i,
    input  wire logic        [15:0] db_hi_i,
    input  wire logic        [15:0] db_hihi_i,
    input  wire logic        [3:0]  cur_i,
    output logic             [3:0]  nxt_o
);
    import cia_pkg::*;

    wire logic signed [17:0] v  = 18'(val_i);
    wire logic signed [17:0] ll_clr = 18'(lolo_i) + $signed({2'b00, db_lolo_i});
    wire logic signed [17:0] l_clr  = 18'(lo_i) + $signed({2'b00, db_lo_i});
    wire logic signed [17:0] h_clr  = 18'(hi_i) - $signed({2'b00, db_hi_i});
    wire logic signed [17:0] hh_clr = 18'(hihi_i) - $signed({2'b00, db_hihi_i});

    // set on reaching limit, hold while inside deadband
    assign nxt_o[ALM_LOLO] = (v <= 18'(lolo_i)) || (cur_i[ALM_LOLO] && v <= ll_clr);
    assign nxt_o[ALM_LO]   = (v <= 18'(lo_i))   || (cur_i[ALM_LO] && v <= l_clr);
    assign nxt_o[ALM_HI]   = (v >= 18'(hi_i))   || (cur_i[ALM_HI] && v >= h_clr);
    assign nxt_o[ALM_HIHI] = (v >= 18'(hihi_i)) || (cur_i[ALM_HIHI] && v >= hh_clr);
endmodule // cia_level_alarm
`default_nettype wire

// ===== core/cia_chan_proc.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - low alarm at or below low limit, high alarm at or above high.
// - alarm stays set until value leaves the deadband past its limit.
// - offset is added to the scaled value before alarm checks, default zero.
// - filter reaches 63.2% in integration time; zero time bypasses it.
// - diagnostic enable reports alarms, each alarm individually enabled.
// - fault enable logs one entry per sample that newly raises enabled alarms, all such bits in it, per-type mask.
// - 4-20 mA range maps 4 mA to 0 and 20 mA to 32000.
// - 0-20 mA range maps 0 mA to 0 and 20 mA to 32000.
// - enhanced range maps 0 mA to -8000, 4 mA to 0.
// - step is 0.625 uA in 0-20 mA, 0.5 uA otherwise.
// - nonzero rate limit: rate is value difference over elapsed time.
// - negative change checks negative limit, positive change positive limit.
// - rate above limit raises rate alarm, then reporting actions apply.
// - rate compared at configured interval, at least 60 ms unless the interval is zero.
// - rate detection blanked 100 ms after run entry or field power return.
// - two value words per channel, float32 or int16 by format.
// - integer format high word is sign extension of low word.
// - two diagnostic words per channel, used or not.
// - diagnostic bit is one only while condition present and enabled.
// - zero rate limit disables that rate alarm.
// - zero comparison interval evaluates rate every sample.
module cia_chan_proc
    import cia_pkg::*;
#(
    parameter int MS_CYC = cia_pkg::MS_CYCLES
)
(
    input  wire logic                  mclk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  cfg_we_i,
    input  wire logic [cia_pkg::CHW-1:0]  cfg_chan_i,
    input  wire logic [cia_pkg::SELW-1:0] cfg_sel_i,
    input  wire logic [15:0]           cfg_data_i,
    input  wire logic                  smp_valid_i,
    input  wire logic [cia_pkg::CHW-1:0]  smp_chan_i,
    input  wire logic [17:0]           smp_raw_i,
    input  wire logic                  run_mode_i,
    input  wire logic                  field_pwr_i,
    input  wire logic [cia_pkg::CHW-1:0]  rd_chan_i,
    output logic      [15:0]           val_lo_o,
    output logic      [15:0]           val_hi_o,
    output logic      [15:0]           diag_w0_o,
    output logic      [15:0]           diag_w1_o,
    output logic                       fault_valid_o,
    output logic      [cia_pkg::CHW-1:0]  fault_chan_o,
    output logic      [cia_pkg::NALM-1:0] fault_bits_o,
    output logic                       rate_blank_o
);
    import cia_pkg::*;

    // ------------------------------------------------------------
    // per-channel storage
    // ------------------------------------------------------------
    logic        [15:0] cfg_q   [CH][NSEL];
    logic signed [23:0] filt_q  [CH];
    logic signed [15:0] val_q   [CH];
    logic signed [15:0] prev_q  [CH];
    logic        [15:0] prevt_q [CH];
    logic [NALM-1:0]    alm_q   [CH];

    // ------------------------------------------------------------
    // millisecond time base and blanking
    // ------------------------------------------------------------
    logic [31:0] mdiv_q;
    logic [15:0] ms_q;
    logic [15:0] blank_q;
    logic [2:0]  fpwr_sync_q;
    logic        fpwr_q;
    logic        run_q;
    wire  logic  ms_tick = (mdiv_q == 32'(MS_CYC - 1));
    wire  logic  fpwr_d  = (fpwr_sync_q[1] == fpwr_sync_q[2]) ? fpwr_sync_q[2] : fpwr_q;
    wire  logic  restart = (run_mode_i && !run_q) || (fpwr_d && !fpwr_q);

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            mdiv_q      <= 32'h0000_0000;
            ms_q        <= 16'h0000;
            blank_q     <= BLANK_MS;
            fpwr_sync_q <= 3'h0;
            fpwr_q      <= 1'b0;
            run_q       <= 1'b0;
        end
        else
        begin
            mdiv_q      <= ms_tick ? 32'h0000_0000 : mdiv_q + 32'h0000_0001;
            ms_q        <= ms_tick ? ms_q + 16'h0001 : ms_q;
            fpwr_sync_q <= {fpwr_sync_q[1:0], field_pwr_i};
            fpwr_q      <= fpwr_d;
            run_q       <= run_mode_i;
            if (restart)
                blank_q <= BLANK_MS;
            else if (ms_tick && blank_q != 16'h0000)
                blank_q <= blank_q - 16'h0001;
        end
    end

    wire logic blanked = (blank_q != 16'h0000) || !run_q || !fpwr_q;
    assign rate_blank_o = blanked;

    // ------------------------------------------------------------
    // selected channel configuration
    // ------------------------------------------------------------
    wire logic [3:0]  ch       = smp_chan_i;
    wire logic [15:0] ctl      = cfg_q[ch][SEL_CTL];
    wire logic [15:0] msk      = cfg_q[ch][SEL_MASK];
    wire logic [15:0] itime    = cfg_q[ch][SEL_ITIME];
    wire logic [15:0] prate    = cfg_q[ch][SEL_PRATE];
    wire logic [15:0] nrate    = cfg_q[ch][SEL_NRATE];
    wire logic [15:0] rintv    = cfg_q[ch][SEL_RINTV];
    wire cia_range_t  rng      = cia_range_t'(ctl[CTL_RNG_LSB +: 2]);

    // ------------------------------------------------------------
    // scaling to counts
    // ------------------------------------------------------------
    wire logic signed [19:0] raw_s   = $signed({2'b00, smp_raw_i});
    wire logic signed [19:0] sc_half = (raw_s - RAW_4MA) >>> SHIFT_05;
    wire logic        [19:0] sc_020  = {2'b00, smp_raw_i} / DIV_0625;
    logic signed [19:0] scaled;
    always_comb
    begin
        unique case (rng)
            RNG_020: scaled = $signed(sc_020);
            RNG_ENH: scaled = sc_half;
            default: scaled = (sc_half < 20'sh00000) ? 20'sh00000 : sc_half;
        endcase
    end

    // ------------------------------------------------------------
    // offset and saturation
    // ------------------------------------------------------------
    wire logic signed [19:0] offs = scaled + 20'($signed(cfg_q[ch][SEL_OFFSET]));
    wire logic signed [15:0] eng  = (offs > CNT_MAX) ? 16'sh7FFF :
                                    (offs < CNT_MIN) ? -16'sh8000 : offs[15:0];

    // ------------------------------------------------------------
    // first-order filter, shift from integration time
    // ------------------------------------------------------------
    logic [3:0] fshift;
    always_comb
    begin
        fshift = 4'h0;
        for (int b = 0; b < 16; b++)
        begin
            if (itime[b])
                fshift = 4'(b);
        end
    end
    wire logic               filt_on = ctl[CTL_FILT] && (itime != 16'h0000);
    wire logic signed [23:0] eng_fx  = {eng, 8'h00};
    wire logic signed [23:0] filt_d  = filt_on ? filt_q[ch] + ((eng_fx - filt_q[ch]) >>> fshift) : eng_fx;
    wire logic signed [15:0] val_d   = filt_d[23:8];

    // ------------------------------------------------------------
    // level alarms
    // ------------------------------------------------------------
    logic [3:0] lvl_d;
    cia_level_alarm u_lvl
    (
        .val_i     (val_d),
        .lolo_i    ($signed(cfg_q[ch][SEL_LOLO])),
        .lo_i      ($signed(cfg_q[ch][SEL_LO])),
        .hi_i      ($signed(cfg_q[ch][SEL_HI])),
        .hihi_i    ($signed(cfg_q[ch][SEL_HIHI])),
        .db_lolo_i (cfg_q[ch][SEL_DB_LL]),
        .db_lo_i   (cfg_q[ch][SEL_DB_L]),
        .db_hi_i   (cfg_q[ch][SEL_DB_H]),
        .db_hihi_i (cfg_q[ch][SEL_DB_HH]),
        .cur_i     (alm_q[ch][3:0]),
        .nxt_o     (lvl_d)
    );

    // ------------------------------------------------------------
    // rate of change
    // ------------------------------------------------------------
    wire logic signed [16:0] diff    = 17'(val_d) - 17'(prev_q[ch]);
    wire logic        [16:0] mag     = diff[16] ? 17'(-diff) : diff;
    wire logic        [15:0] dt_raw  = ms_q - prevt_q[ch];
    wire logic        [15:0] dt      = (dt_raw == 16'h0000) ? 16'h0001 : dt_raw;
    wire logic        [15:0] intv    = (rintv < RATE_MIN_MS) ? RATE_MIN_MS : rintv;
    wire logic               due     = (rintv == 16'h0000) || (dt_raw >= intv);
    wire logic               rate_on = (prate != 16'h0000) || (nrate != 16'h0000);
    wire logic        [31:0] lhs     = 32'(mag) * 32'(MS_PER_S);
    wire logic        [31:0] rhs_p   = 32'(prate) * 32'(dt);
    wire logic        [31:0] rhs_n   = 32'(nrate) * 32'(dt);
    wire logic pos_d = !diff[16] && (prate != 16'h0000) && (lhs > rhs_p);
    wire logic neg_d =  diff[16] && (nrate != 16'h0000) && (lhs > rhs_n);
    wire logic rate_upd = due || blanked;
    wire logic [1:0] rate_d = blanked ? 2'b00 :
                              (due && rate_on) ? {pos_d, neg_d} :
                              !rate_on ? 2'b00 : alm_q[ch][ALM_POS:ALM_NEG];

    wire logic [NALM-1:0] alm_d  = {rate_d, lvl_d};
    wire logic [NALM-1:0] rising = alm_d & ~alm_q[ch] & msk[MASK_FAULT +: NALM];

    // ------------------------------------------------------------
    // channel state update
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int c = 0; c < CH; c++)
            begin
                for (int s = 0; s < NSEL; s++)
                    cfg_q[c][s] <= CFG_RESET;
                filt_q[c]  <= 24'sh000000;
                val_q[c]   <= 16'sh0000;
                prev_q[c]  <= 16'sh0000;
                prevt_q[c] <= 16'h0000;
                alm_q[c]   <= '0;
            end
        end
        else
        begin
            if (cfg_we_i)
                cfg_q[cfg_chan_i][cfg_sel_i] <= cfg_data_i;
            // held rate alarms drop while blanked
            if (blanked)
                for (int c = 0; c < CH; c++)
                    alm_q[c][ALM_POS:ALM_NEG] <= 2'b00;
            if (smp_valid_i)
            begin
                filt_q[ch] <= filt_d;
                val_q[ch]  <= val_d;
                alm_q[ch]  <= alm_d;
                if (rate_upd)
                begin
                    prev_q[ch]  <= val_d;
                    prevt_q[ch] <= ms_q;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // fault log entries
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            fault_valid_o <= 1'b0;
            fault_chan_o  <= '0;
            fault_bits_o  <= '0;
        end
        else
        begin
            fault_valid_o <= smp_valid_i && ctl[CTL_FAULT] && (rising != '0);
            if (smp_valid_i)
            begin
                fault_chan_o <= ch;
                fault_bits_o <= ctl[CTL_FAULT] ? rising : '0;
            end
        end
    end

    // ------------------------------------------------------------
    // int16 to float32
    // ------------------------------------------------------------
    function automatic logic [31:0] to_float(input logic signed [15:0] v);
        logic [15:0] a;
        logic [3:0]  m;
        logic [38:0] sh;
        a  = v[15] ? 16'(-v) : 16'(v);
        m  = 4'h0;
        sh = '0;
        for (int b = 0; b < 16; b++)
        begin
            if (a[b])
                m = 4'(b);
        end
        sh = 39'(a) << (5'd23 - 5'(m));
        if (a == 16'h0000)
            to_float = 32'h0000_0000;
        else
            to_float = {v[15], 8'(8'd127 + 8'(m)), sh[22:0]};
    endfunction

    // ------------------------------------------------------------
    // read port: value and diagnostic words
    // ------------------------------------------------------------
    wire logic [15:0] rctl  = cfg_q[rd_chan_i][SEL_CTL];
    wire logic [15:0] rmsk  = cfg_q[rd_chan_i][SEL_MASK];
    wire logic signed [15:0] rval = val_q[rd_chan_i];
    wire logic [31:0] rflt  = to_float(rval);
    wire logic [15:0] rhi   = rctl[CTL_FMT] ? (rval[15] ? SIGN_NEG : SIGN_POS) : rflt[31:16];
    wire logic [15:0] rlo   = rctl[CTL_FMT] ? rval : rflt[15:0];
    wire logic [NALM-1:0] rdiag = rctl[CTL_DIAG] ? (alm_q[rd_chan_i] & rmsk[MASK_DIAG +: NALM]) : '0;

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            val_lo_o  <= 16'h0000;
            val_hi_o  <= 16'h0000;
            diag_w0_o <= 16'h0000;
            diag_w1_o <= 16'h0000;
        end
        else
        begin
            val_lo_o  <= rlo;
            val_hi_o  <= rhi;
            diag_w0_o <= 16'(rdiag);
            diag_w1_o <= 16'h0000;
        end
    end
endmodule // cia_chan_proc
`default_nettype wire

// ===== tb/cia_chan_proc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cia_chan_proc_chk
    import cia_pkg::*;
#(
    parameter int MS_CYC = 10
)
(
    input  wire logic                      mclk_i,
    input  wire logic                      arst_n_i,
    input  wire logic                      smp_valid_i,
    input  wire logic [cia_pkg::CHW-1:0]   smp_chan_i,
    input  wire logic                      run_mode_i,
    input  wire logic                      field_pwr_i,
    input  wire logic [15:0]               diag_w0_o,
    input  wire logic [15:0]               diag_w1_o,
    input  wire logic                      fault_valid_o,
    input  wire logic [cia_pkg::CHW-1:0]   fault_chan_o,
    input  wire logic [cia_pkg::NALM-1:0]  fault_bits_o,
    input  wire logic                      rate_blank_o
);
    // ------------------------------------------------------------
    // blanking length while both start conditions hold
    // ------------------------------------------------------------
    int blank_cnt_q;
    always_ff @(posedge mclk_i or negedge arst_n_i)
        if (!arst_n_i)
            blank_cnt_q <= 0;
        else if (rate_blank_o && run_mode_i && field_pwr_i)
            blank_cnt_q <= blank_cnt_q + 1;
        else
            blank_cnt_q <= 0;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_flt_cause; fault_valid_o |-> $past(smp_valid_i); endproperty
    a_flt_cause: assert property (p_flt_cause) else $error("fault entry without sample");
    property p_flt_chan; fault_valid_o |-> fault_chan_o == $past(smp_chan_i); endproperty
    a_flt_chan: assert property (p_flt_chan) else $error("fault entry channel");
    property p_flt_bits; fault_valid_o |-> fault_bits_o != '0; endproperty
    a_flt_bits: assert property (p_flt_bits) else $error("fault entry empty");
    property p_flt_hold; !smp_valid_i |=> $stable(fault_chan_o) && $stable(fault_bits_o); endproperty
    a_flt_hold: assert property (p_flt_hold) else $error("fault data moved");
    property p_diag_w1; diag_w1_o == 16'h0000; endproperty
    a_diag_w1: assert property (p_diag_w1) else $error("second diag word set");
    property p_diag_top; diag_w0_o[15:6] == 10'h000; endproperty
    a_diag_top: assert property (p_diag_top) else $error("unused diag bit set");
    property p_blank_off; !run_mode_i |=> rate_blank_o; endproperty
    a_blank_off: assert property (p_blank_off) else $error("rate not blanked");
    property p_blank_long; $fell(rate_blank_o) && run_mode_i |-> blank_cnt_q >= 99 * MS_CYC; endproperty
    a_blank_long: assert property (p_blank_long) else $error("blanking too short");
    property p_blank_end; blank_cnt_q <= 102 * MS_CYC + 8; endproperty
    a_blank_end: assert property (p_blank_end) else $error("blanking too long");
    property p_rate_clear; rate_blank_o [*3] |-> diag_w0_o[5:4] == 2'b00; endproperty
    a_rate_clear: assert property (p_rate_clear) else $error("rate alarm while blanked");
endmodule // cia_chan_proc_chk

bind cia_chan_proc cia_chan_proc_chk #(.MS_CYC(MS_CYC)) i_chk (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .smp_valid_i(smp_valid_i), .smp_chan_i(smp_chan_i),
    .run_mode_i(run_mode_i), .field_pwr_i(field_pwr_i), .diag_w0_o(diag_w0_o), .diag_w1_o(diag_w1_o),
    .fault_valid_o(fault_valid_o), .fault_chan_o(fault_chan_o), .fault_bits_o(fault_bits_o),
    .rate_blank_o(rate_blank_o));
`default_nettype wire

// ===== tb/cia_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module cia_cpu_model
    import cia_pkg::*;
(
    input  wire logic                     mclk_i,
    input  wire logic [15:0]              val_lo_i,
    input  wire logic [15:0]              val_hi_i,
    input  wire logic [15:0]              diag_w0_i,
    output logic      [cia_pkg::CHW-1:0]  rd_chan_o
);
    import cia_pkg::*;
    initial rd_chan_o = '0;

    // select a channel, take its two value words and diag word next edge
    task automatic rd(input logic [3:0] ch, output logic [15:0] lo, output logic [15:0] hi,
                      output logic [15:0] dg);
        @(negedge mclk_i);
        rd_chan_o = ch;
        @(negedge mclk_i);
        lo = val_lo_i;
        hi = val_hi_i;
        dg = diag_w0_i;
    endtask
endmodule // cia_cpu_model
`default_nettype wire

// ===== tb/current_input_alarm_processing_tb.sv
`timescale 1ns/10ps
`default_nettype none
module current_input_alarm_processing_tb;
    import cia_pkg::*;
    localparam int MSC = 10;
    localparam int SC_RAW [5] = '{36000, 160000, 0, 160000, 36000};
    localparam logic [15:0] SC_CTL [5] = '{16'h0004, 16'h0005, 16'h0007, 16'h0004, 16'h0000};
    localparam logic [15:0] SC_LO [5] = '{16'h03E8, 16'h7D00, 16'hE0C0, 16'h7D00, 16'h0000};
    localparam logic [15:0] SC_HI [5] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h447A};
    logic        mclk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        cfg_we_i = 1'b0;
    logic [3:0]  cfg_chan_i = 4'h0;
    logic [3:0]  cfg_sel_i = 4'h0;
    logic [15:0] cfg_data_i = 16'h0000;
    logic        smp_valid_i = 1'b0;
    logic [3:0]  smp_chan_i = 4'h0;
    logic [17:0] smp_raw_i = 18'h00000;
    logic        run_mode_i = 1'b0;
    logic        field_pwr_i = 1'b1;
    logic [3:0]  rd_chan_i;
    logic [15:0] val_lo_o, val_hi_o, diag_w0_o, diag_w1_o, lo, hi, dg;
    logic        fault_valid_o, rate_blank_o;
    logic [3:0]  fault_chan_o;
    logic [5:0]  fault_bits_o, fbits = 6'h00;
    int          errors = 0;
    int          comparisons = 0;
    int          nflt = 0;

    always #10 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
        if (fault_valid_o)
        begin
            nflt++;
            fbits = fault_bits_o;
        end

    cia_chan_proc #(.MS_CYC(MSC)) i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cfg_we_i(cfg_we_i),
        .cfg_chan_i(cfg_chan_i), .cfg_sel_i(cfg_sel_i), .cfg_data_i(cfg_data_i), .smp_valid_i(smp_valid_i),
        .smp_chan_i(smp_chan_i), .smp_raw_i(smp_raw_i), .run_mode_i(run_mode_i), .field_pwr_i(field_pwr_i),
        .rd_chan_i(rd_chan_i), .val_lo_o(val_lo_o), .val_hi_o(val_hi_o), .diag_w0_o(diag_w0_o),
        .diag_w1_o(diag_w1_o), .fault_valid_o(fault_valid_o), .fault_chan_o(fault_chan_o),
        .fault_bits_o(fault_bits_o), .rate_blank_o(rate_blank_o));
    cia_cpu_model i_cpu (.mclk_i(mclk_i), .val_lo_i(val_lo_o), .val_hi_i(val_hi_o),
        .diag_w0_i(diag_w0_o), .rd_chan_o(rd_chan_i));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cfg(input logic [3:0] ch, input logic [3:0] sel, input logic [15:0] d);
        @(negedge mclk_i);
        cfg_we_i = 1'b1;
        cfg_chan_i = ch;
        cfg_sel_i = sel;
        cfg_data_i = d;
        @(negedge mclk_i);
        cfg_we_i = 1'b0;
    endtask

    // raw for 4-20 mA value v: 4 mA offset plus 4 steps per count
    task automatic smp(input logic [3:0] ch, input int v, input bit eng);
        @(negedge mclk_i);
        smp_valid_i = 1'b1;
        smp_chan_i = ch;
        smp_raw_i = eng ? 18'(32000 + 4 * v) : 18'(v);
        @(negedge mclk_i);
        smp_valid_i = 1'b0;
    endtask

    task automatic t_scale;
        foreach (SC_RAW[i])
        begin
            cfg(4'h0, SEL_CTL, SC_CTL[i]);
            smp(4'h0, SC_RAW[i], 1'b0);
            i_cpu.rd(4'h0, lo, hi, dg);
            chk(lo, SC_LO[i]);
            chk(hi, SC_HI[i]);
        end
        cfg(4'h0, SEL_CTL, 16'h0004);
        cfg(4'h0, SEL_OFFSET, 16'hFFFB);
        smp(4'h0, 36000, 1'b0);
        i_cpu.rd(4'h0, lo, hi, dg);
        chk(lo, 16'h03E3);
    endtask

    task automatic t_alarm;
        int n;
        int v [6] = '{500, 100, 150, 151, 2000, 3000};
        logic [15:0] ex [6] = '{16'h0000, 16'h0002, 16'h0002, 16'h0000, 16'h0004, 16'h000C};
        cfg(4'h2, SEL_CTL, 16'h0034);
        cfg(4'h2, SEL_MASK, 16'h023F);
        cfg(4'h2, SEL_LOLO, 16'hFC18);
        cfg(4'h2, SEL_LO, 16'h0064);
        cfg(4'h2, SEL_HI, 16'h07D0);
        cfg(4'h2, SEL_HIHI, 16'h0BB8);
        cfg(4'h2, SEL_DB_L, 16'h0032);
        foreach (v[i])
        begin
            n = nflt;
            smp(4'h2, v[i], 1'b1);
            i_cpu.rd(4'h2, lo, hi, dg);
            chk(dg, ex[i]);
            chk(16'(nflt - n), (i == 1) ? 16'h0001 : 16'h0000);
        end
        chk({10'h000, fbits}, 16'h0002);
        cfg(4'h2, SEL_MASK, 16'h0200);
        i_cpu.rd(4'h2, lo, hi, dg);
        chk(dg, 16'h0000);
    endtask

    task automatic t_filter;
        cfg(4'h4, SEL_CTL, 16'h000C);
        cfg(4'h4, SEL_ITIME, 16'h0004);
        smp(4'h4, 1000, 1'b1);
        i_cpu.rd(4'h4, lo, hi, dg);
        chk(16'(lo < 16'd1000), 16'h0001);
        repeat (3) smp(4'h4, 1000, 1'b1);
        i_cpu.rd(4'h4, lo, hi, dg);
        chk(16'(lo >= 16'd632), 16'h0001);
        cfg(4'h4, SEL_ITIME, 16'h0000);
        smp(4'h4, 200, 1'b1);
        i_cpu.rd(4'h4, lo, hi, dg);
        chk(lo, 16'h00C8);
    endtask

    task automatic t_blank;
        chk({15'h0, rate_blank_o}, 16'h0001);
        for (int k = 0; k < 2; k++)
        begin
            @(negedge mclk_i);
            if (k == 0)
                run_mode_i = 1'b1;
            else
            begin
                field_pwr_i = 1'b0;
                repeat (8) @(negedge mclk_i);
                chk({15'h0, rate_blank_o}, 16'h0001);
                field_pwr_i = 1'b1;
            end
            repeat (95 * MSC) @(negedge mclk_i);
            chk({15'h0, rate_blank_o}, 16'h0001);
            repeat (10 * MSC) @(negedge mclk_i);
            chk({15'h0, rate_blank_o}, 16'h0000);
        end
    endtask

    task automatic t_rate;
        int v [4] = '{1100, 1000, 1001, 801};
        logic [15:0] ex [4] = '{16'h0020, 16'h0000, 16'h0000, 16'h0010};
        cfg(4'h3, SEL_CTL, 16'h0014);
        cfg(4'h3, SEL_MASK, 16'h0030);
        cfg(4'h3, SEL_PRATE, 16'h03E8);
        smp(4'h3, 1000, 1'b1);
        foreach (v[i])
        begin
            if (i == 3)
                cfg(4'h3, SEL_NRATE, 16'h03E8);
            repeat (2 * MSC) @(negedge mclk_i);
            smp(4'h3, v[i], 1'b1);
            i_cpu.rd(4'h3, lo, hi, dg);
            chk(dg, ex[i]);
        end
        run_mode_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        i_cpu.rd(4'h3, lo, hi, dg);
        chk(dg, 16'h0000);
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk_i);
        errors++;
        conclude();
    end

    initial
    begin
        repeat (4) @(posedge mclk_i);
        chk(val_lo_o, 16'h0000);
        chk({15'h0, rate_blank_o}, 16'h0001);
        @(negedge mclk_i);
        arst_n_i = 1'b1;
        t_scale();
        t_alarm();
        t_filter();
        t_blank();
        t_rate();
        conclude();
    end
endmodule // current_input_alarm_processing_tb
`default_nettype wire
